// ===== tic_pkg.sv
// Constants, register map and types for the trigger input conditioning block
package tic_pkg;

  // Clock and action-command release timing
  localparam int unsigned TIC_CLK_NS = 20;
  localparam int unsigned TIC_TICK_NS = 15;
  localparam int unsigned TIC_NET_MIN_NS = 25605;
  localparam int unsigned TIC_NET_MAX_NS = 50130;
  localparam int unsigned TIC_NET_MIN_CYC = (TIC_NET_MIN_NS + TIC_CLK_NS - 1) / TIC_CLK_NS;
  localparam int unsigned TIC_NET_MAX_CYC = TIC_NET_MAX_NS / TIC_CLK_NS;
  localparam logic [11:0] TIC_NET_LOAD = 12'(TIC_NET_MIN_CYC - 1);

  // Register byte offsets
  localparam logic [7:0] TIC_OFS_CTRL = 8'h00;
  localparam logic [7:0] TIC_OFS_STABLE = 8'h04;
  localparam logic [7:0] TIC_OFS_PRESCALE = 8'h08;
  localparam logic [7:0] TIC_OFS_DEV_KEY = 8'h0c;
  localparam logic [7:0] TIC_OFS_GRP_KEY = 8'h10;
  localparam logic [7:0] TIC_OFS_GRP_MASK = 8'h14;
  localparam logic [7:0] TIC_OFS_STATUS = 8'h18;
  localparam logic [7:0] TIC_OFS_BAUD = 8'h1c;
  localparam logic [7:0] TIC_OFS_TXDATA = 8'h20;
  localparam logic [7:0] TIC_OFS_RXDATA = 8'h24;
  localparam logic [7:0] TIC_OFS_HITS = 8'h28;

  // Control register field positions
  localparam int TIC_CTL_FUNC0 = 0;
  localparam int TIC_CTL_FUNC1 = 3;
  localparam int TIC_CTL_SELA0 = 6;
  localparam int TIC_CTL_SELB0 = 9;
  localparam int TIC_CTL_SELA1 = 12;
  localparam int TIC_CTL_SELB1 = 15;
  localparam int TIC_CTL_DBSRC = 18;
  localparam int TIC_CTL_DBEN = 20;
  localparam int TIC_CTL_TRIG1 = 21;
  localparam int TIC_CTL_OUT1 = 22;

  // Reset values
  localparam logic [31:0] TIC_RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] TIC_RST_STABLE = 32'h0001_046a;
  localparam logic [3:0] TIC_RST_PRESCALE = 4'h0;
  localparam logic [15:0] TIC_RST_BAUD = 16'h01b1;

  // UART frame: start, eight data bits, stop
  localparam logic [3:0] TIC_UART_BITS = 4'h9;

  // Combiner functions
  typedef enum logic [2:0] {
    TIC_F_AND = 3'h0,
    TIC_F_NAND = 3'h1,
    TIC_F_OR = 3'h2,
    TIC_F_NOR = 3'h3,
    TIC_F_XOR = 3'h4,
    TIC_F_XNOR = 3'h5,
    TIC_F_TRIGEN = 3'h6
  } tic_func_t;

endpackage : tic_pkg

// ===== tic_top.sv
// Trigger input conditioning: combiner, debouncer, prescaler, action filter, UART
// Notes on behaviour
// - Six two-input functions with standard truth tables
// - Each operation takes exactly two selected operands
// - Trigger-enable function gates first operand by second
// - Result routes to trigger, output line, chaining
// - Level passes only after stable programmed duration
// - Duration counted in system clock ticks
// - Debouncer placed and enabled on selected line
// - Four-bit divisor, sixteen settings, maximum sixteen
// - Prescaler passes one of divisor pulses
// - Hold device key, group key, group mask
// - Fire on both keys equal, masks overlap
// - Unicast and broadcast commands evaluated alike
// - Trigger released 25605 to 50130 ns later
// - UART frames characters with start, stop bits
// - Bit rate configured before any transfer
// - Separate receive and transmit data lines
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
module tic_top
  import tic_pkg::*;
#(
  parameter int LINES = 4
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LINES-1:0] input_line,
  input wire logic network_trigger_packet,
  input wire logic [31:0] pkt_device_auth_key,
  input wire logic [31:0] pkt_group_select_key,
  input wire logic [31:0] pkt_group_filter_mask,
  output logic cam_trigger,
  output logic out_line,
  input wire logic rxd,
  output logic txd
);

  // Selector fields are three bits wide and the debounce source two bits
  if (LINES != 4) begin : g_bad_lines
    $error("tic_top supports exactly four input lines");
  end

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] stable_time_ticks;
    logic [3:0] divisor;
    logic [31:0] device_auth_key;
    logic [31:0] group_select_key;
    logic [31:0] group_filter_mask;
    logic [15:0] baud_div;
    logic [LINES-1:0] in_meta;
    logic [LINES-1:0] in_sync;
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic db_level;
    logic [31:0] db_cnt;
    logic res_prev;
    logic [3:0] pre_cnt;
    logic net_busy;
    logic [11:0] net_cnt;
    logic [15:0] net_hits;
    logic cam_trigger;
    logic out_line;
    logic tx_busy;
    logic [9:0] tx_sh;
    logic [3:0] tx_bit;
    logic [15:0] tx_cnt;
    logic txd;
    logic rx_busy;
    logic [7:0] rx_sh;
    logic [3:0] rx_bit;
    logic [15:0] rx_cnt;
    logic [7:0] rx_data;
    logic rx_full;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } tic_state_t;

  tic_state_t st;
  tic_state_t next_st;

  // Two-input combiner, standard truth tables
  function automatic logic tic_comb(input logic [2:0] f, input logic a, input logic b);
    case (f)
      TIC_F_AND: tic_comb = a & b;
      TIC_F_NAND: tic_comb = ~(a & b);
      TIC_F_OR: tic_comb = a | b;
      TIC_F_NOR: tic_comb = ~(a | b);
      TIC_F_XOR: tic_comb = a ^ b;
      TIC_F_XNOR: tic_comb = ~(a ^ b);
      TIC_F_TRIGEN: tic_comb = b ? a : 1'b0;
      default: tic_comb = 1'b0;
    endcase
  endfunction : tic_comb

  // Address decode for mapped registers
  function automatic logic tic_mapped(input logic [7:0] a);
    tic_mapped = (a == TIC_OFS_CTRL) || (a == TIC_OFS_STABLE) || (a == TIC_OFS_PRESCALE)
      || (a == TIC_OFS_DEV_KEY) || (a == TIC_OFS_GRP_KEY) || (a == TIC_OFS_GRP_MASK)
      || (a == TIC_OFS_STATUS) || (a == TIC_OFS_BAUD) || (a == TIC_OFS_TXDATA)
      || (a == TIC_OFS_RXDATA) || (a == TIC_OFS_HITS);
  endfunction : tic_mapped

  logic [7:0] src0;
  logic [7:0] src1;
  logic r0;
  logic r1;
  logic result;
  logic raw_db;
  logic setup;
  logic wr;
  logic rd;
  logic key_match;
  logic fire_hw;
  logic [32:0] db_next_cnt;

  // Operand sources, stage one can chain the stage zero result
  assign src0 = {3'h0, st.db_level, st.in_sync};
  assign src1 = {2'h0, r0, st.db_level, st.in_sync};
  assign r0 = tic_comb(st.ctrl[TIC_CTL_FUNC0 +: 3], src0[st.ctrl[TIC_CTL_SELA0 +: 3]],
    src0[st.ctrl[TIC_CTL_SELB0 +: 3]]);
  assign r1 = tic_comb(st.ctrl[TIC_CTL_FUNC1 +: 3], src1[st.ctrl[TIC_CTL_SELA1 +: 3]],
    src1[st.ctrl[TIC_CTL_SELB1 +: 3]]);
  assign result = st.ctrl[TIC_CTL_TRIG1] ? r1 : r0;
  assign raw_db = st.in_sync[st.ctrl[TIC_CTL_DBSRC +: 2]];
  assign db_next_cnt = {1'b0, st.db_cnt} + 33'h0_0000_0001;

  // Bus phases; the access phase always completes in its first cycle
  assign setup = psel & ~penable & ~st.pready;
  assign wr = psel & penable & pwrite & st.pready;
  assign rd = psel & penable & ~pwrite & st.pready;

  // Both keys equal and at least one shared group bit
  assign key_match = (pkt_device_auth_key == st.device_auth_key)
    && (pkt_group_select_key == st.group_select_key)
    && ((pkt_group_filter_mask & st.group_filter_mask) != 32'h0000_0000);
  assign fire_hw = result & ~st.res_prev;

  // Next-state logic for the whole block
  always_comb
  begin
    next_st = st;
    // Pin synchronisers
    next_st.in_meta = input_line;
    next_st.in_sync = st.in_meta;
    next_st.rx_meta = rxd;
    next_st.rx_sync = st.rx_meta;
    next_st.rx_prev = st.rx_sync;
    next_st.cam_trigger = 1'b0;
    next_st.pready = 1'b0;

    // Debouncer on the selected line; the counter restarts whenever raw matches
    next_st.db_cnt = 32'h0000_0000;
    if (!st.ctrl[TIC_CTL_DBEN] || db_next_cnt >= {1'b0, st.stable_time_ticks})
    begin
      next_st.db_level = raw_db;
    end
    else if (raw_db != st.db_level)
    begin
      next_st.db_cnt = db_next_cnt[31:0];
    end

    // Combined result to output line, edges to prescaler
    next_st.out_line = st.ctrl[TIC_CTL_OUT1] ? r1 : r0;
    next_st.res_prev = result;
    if (fire_hw)
    begin
      next_st.pre_cnt = (st.pre_cnt == st.divisor) ? 4'h0 : st.pre_cnt + 4'h1;
      next_st.cam_trigger = (st.pre_cnt == st.divisor);
    end

    // Action command filter and release delay
    if (st.net_busy)
    begin
      next_st.net_cnt = st.net_cnt - 12'h001;
      if (st.net_cnt == 12'h000)
      begin
        next_st.net_busy = 1'b0;
        next_st.cam_trigger = 1'b1;
        next_st.net_hits = st.net_hits + 16'h0001;
      end
    end
    else if (network_trigger_packet && key_match)
    begin
      next_st.net_busy = 1'b1;
      next_st.net_cnt = TIC_NET_LOAD;
    end

    // UART transmitter, LSB first
    if (st.tx_busy)
    begin
      next_st.tx_cnt = st.tx_cnt - 16'h0001;
      if (st.tx_cnt == 16'h0000)
      begin
        next_st.tx_cnt = st.baud_div;
        next_st.txd = st.tx_sh[0];
        next_st.tx_sh = {1'b1, st.tx_sh[9:1]};
        next_st.tx_busy = st.tx_bit != TIC_UART_BITS;
        next_st.tx_bit = st.tx_bit + 4'h1;
      end
    end

    // Read of receive data clears the full flag; a new character below wins
    if (rd && paddr == TIC_OFS_RXDATA)
    begin
      next_st.rx_full = 1'b0;
    end

    // UART receiver, waits for a falling start edge, samples at mid-bit
    if (!st.rx_busy)
    begin
      next_st.rx_busy = st.rx_prev & ~st.rx_sync;
      next_st.rx_bit = 4'h0;
      next_st.rx_cnt = {1'b0, st.baud_div[15:1]};
    end
    else if (st.rx_cnt != 16'h0000)
    begin
      next_st.rx_cnt = st.rx_cnt - 16'h0001;
    end
    else
    begin
      next_st.rx_cnt = st.baud_div;
      next_st.rx_bit = st.rx_bit + 4'h1;
      if (st.rx_bit == 4'h0)
      begin
        next_st.rx_busy = ~st.rx_sync;
      end
      else if (st.rx_bit == TIC_UART_BITS)
      begin
        next_st.rx_busy = 1'b0;
        if (st.rx_sync)
        begin
          next_st.rx_data = st.rx_sh;
          next_st.rx_full = 1'b1;
        end
      end
      else
      begin
        next_st.rx_sh = {st.rx_sync, st.rx_sh[7:1]};
      end
    end

    // Register reads captured in the setup cycle
    if (setup)
    begin
      next_st.pready = 1'b1;
      next_st.pslverr = ~tic_mapped(paddr);
      case (paddr)
        TIC_OFS_CTRL: next_st.prdata = st.ctrl;
        TIC_OFS_STABLE: next_st.prdata = st.stable_time_ticks;
        TIC_OFS_PRESCALE: next_st.prdata = {28'h000_0000, st.divisor};
        TIC_OFS_DEV_KEY: next_st.prdata = st.device_auth_key;
        TIC_OFS_GRP_KEY: next_st.prdata = st.group_select_key;
        TIC_OFS_GRP_MASK: next_st.prdata = st.group_filter_mask;
        TIC_OFS_STATUS: next_st.prdata = {22'h00_0000, st.rx_full, st.tx_busy, st.net_busy,
          r1, r0, st.db_level, st.in_sync};
        TIC_OFS_BAUD: next_st.prdata = {16'h0000, st.baud_div};
        TIC_OFS_RXDATA: next_st.prdata = {23'h00_0000, st.rx_full, st.rx_data};
        TIC_OFS_HITS: next_st.prdata = {16'h0000, st.net_hits};
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end

    // Register writes at the completing access edge
    if (wr)
    begin
      case (paddr)
        TIC_OFS_CTRL: next_st.ctrl = pwdata;
        TIC_OFS_STABLE: next_st.stable_time_ticks = pwdata;
        TIC_OFS_PRESCALE:
        begin
          next_st.divisor = pwdata[3:0];
          next_st.pre_cnt = 4'h0;
        end
        TIC_OFS_DEV_KEY: next_st.device_auth_key = pwdata;
        TIC_OFS_GRP_KEY: next_st.group_select_key = pwdata;
        TIC_OFS_GRP_MASK: next_st.group_filter_mask = pwdata;
        TIC_OFS_BAUD: next_st.baud_div = pwdata[15:0];
        TIC_OFS_TXDATA:
        begin
          if (!st.tx_busy)
          begin
            next_st.tx_busy = 1'b1;
            next_st.tx_sh = {1'b1, pwdata[7:0], 1'b0};
            next_st.tx_bit = 4'h0;
            next_st.tx_cnt = 16'h0000;
          end
        end
        default: next_st.ctrl = st.ctrl;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.ctrl <= TIC_RST_CTRL;
      st.stable_time_ticks <= TIC_RST_STABLE;
      st.divisor <= TIC_RST_PRESCALE;
      st.baud_div <= TIC_RST_BAUD;
      st.rx_meta <= 1'b1;
      st.rx_sync <= 1'b1;
      st.rx_prev <= 1'b1;
      st.tx_sh <= 10'h3ff;
      st.txd <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign cam_trigger = st.cam_trigger;
  assign out_line = st.out_line;
  assign txd = st.txd;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_prescale_restart: assert property (wr && paddr == TIC_OFS_PRESCALE |=> st.pre_cnt == 4'h0)
    else $error("prescale counter not cleared on divisor write");
  a_prescale_bound: assert property (fire_hw && st.pre_cnt != st.divisor && !st.net_busy
    |=> !cam_trigger)
    else $error("prescaler passed a masked pulse");
  a_debounce_restart: assert property (st.ctrl[TIC_CTL_DBEN] && raw_db == st.db_level
    |=> st.db_cnt == 32'h0000_0000)
    else $error("debounce counter not restarted");
  a_debounce_hold: assert property (st.ctrl[TIC_CTL_DBEN] && !wr && raw_db != st.db_level
    && db_next_cnt < {1'b0, st.stable_time_ticks} |=> $stable(st.db_level))
    else $error("debounced level changed too early");
  a_net_start: assert property (!st.net_busy && network_trigger_packet && key_match
    |=> st.net_busy && st.net_cnt == TIC_NET_LOAD)
    else $error("matching action command not accepted");
  a_net_reject: assert property (!st.net_busy && !(network_trigger_packet && key_match)
    |=> !st.net_busy)
    else $error("non-matching action command accepted");
  a_net_release: assert property (st.net_busy && st.net_cnt == 12'h000
    |=> cam_trigger && !st.net_busy)
    else $error("trigger not released at end of delay");
  a_tx_frame: assert property ($rose(st.tx_busy) |=> ##[0:1] !txd)
    else $error("start bit missing");
  a_tx_idle: assert property ($fell(st.tx_busy) |-> txd)
    else $error("stop bit missing");
  a_apb_answer: assert property (setup |=> pready ##1 !pready)
    else $error("bus answer not one cycle");
  a_out_route: assert property (##1 out_line
    == ($past(st.ctrl[TIC_CTL_OUT1]) ? $past(r1) : $past(r0)))
    else $error("output line not routed from combiner");

endmodule : tic_top

// ===== tic_partner.sv
// Model of the trigger sources, the networked host and the far UART end
`timescale 1ns/100ps
module tic_partner #(
  parameter int BIT_CYC = 4
)(
  input wire logic pclk,
  output logic [3:0] input_line,
  output logic network_trigger_packet,
  output logic [31:0] pkt_device_auth_key,
  output logic [31:0] pkt_group_select_key,
  output logic [31:0] pkt_group_filter_mask,
  output logic rxd,
  input wire logic txd
);
  logic [7:0] echo;

  // Idle levels at time zero, serial line idles high
  initial
  begin
    input_line = 4'h0;
    network_trigger_packet = 1'b0;
    pkt_device_auth_key = 32'h0000_0000;
    pkt_group_select_key = 32'h0000_0000;
    pkt_group_filter_mask = 32'h0000_0000;
    rxd = 1'b1;
  end

  // Trigger lines change just after a clock edge
  task automatic set_lines(input logic [3:0] v);
    @(posedge pclk);
    input_line <= v;
  endtask : set_lines

  // One action command; fields are only valid with the pulse
  task automatic send_cmd(input logic [31:0] dk, input logic [31:0] gk, input logic [31:0] gm);
    @(posedge pclk);
    network_trigger_packet <= 1'b1;
    pkt_device_auth_key <= dk;
    pkt_group_select_key <= gk;
    pkt_group_filter_mask <= gm;
    @(posedge pclk);
    network_trigger_packet <= 1'b0;
    pkt_device_auth_key <= ~dk;
    pkt_group_select_key <= ~gk;
    pkt_group_filter_mask <= ~gm;
  endtask : send_cmd

  // Echo: takes one 8N1 character, LSB first, at the agreed rate and sends it back
  always
  begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge pclk);
      echo[i] = txd;
    end
    repeat (BIT_CYC) @(posedge pclk);
    for (int i = 0; i < 10; i++)
    begin
      rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : echo[i-1];
      repeat (BIT_CYC) @(posedge pclk);
    end
  end
endmodule : tic_partner

// ===== tic_top_tb.sv
// Self-checking testbench for the trigger input conditioning block
`timescale 1ns/100ps
module tic_top_tb;
  import tic_pkg::*;
  localparam logic [31:0] BAUD = 32'h0000_0003;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pkt, cam_trigger, out_line;
  logic rxd, txd, rerr;
  logic [7:0] paddr;
  logic [3:0] lines;
  logic [31:0] pwdata, prdata, rdat, seed, dk, gk, gm, dkp, gkp, gmp;
  int mismatches = 0, tests_run = 0, trig_count = 0, base, n;

  tic_top u_tic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_line(lines), .network_trigger_packet(pkt),
    .pkt_device_auth_key(dkp), .pkt_group_select_key(gkp), .pkt_group_filter_mask(gmp),
    .cam_trigger(cam_trigger), .out_line(out_line), .rxd(rxd), .txd(txd));
  tic_partner #(.BIT_CYC(4)) u_tic_partner (.pclk(pclk), .input_line(lines),
    .network_trigger_packet(pkt), .pkt_device_auth_key(dkp), .pkt_group_select_key(gkp),
    .pkt_group_filter_mask(gmp), .rxd(rxd), .txd(txd));

  // Clock and trigger pulse counter
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (cam_trigger === 1'b1) trig_count <= trig_count + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected combiner result
  function automatic logic fn(input int f, input logic a, input logic b);
    case (f)
      0: return a & b;
      1: return ~(a & b);
      2: return a | b;
      3: return ~(a | b);
      4: return a ^ b;
      5: return ~(a ^ b);
      6: return b ? a : 1'b0;
      default: return 1'b0;
    endcase
  endfunction : fn

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  // One APB transfer, zero or more wait states
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      $display("mismatch at %0t: pready %h expected %h", $time, pready, 1'b1);
      mismatches++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
    chk({31'h0, rerr}, {31'h0, err});
  endtask : rd

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // Watchdog against a hang
  initial
  begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    seed = 32'h326c_45fc;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped address
    rd(TIC_OFS_CTRL, TIC_RST_CTRL, 1'b0);
    rd(TIC_OFS_STABLE, TIC_RST_STABLE, 1'b0);
    rd(TIC_OFS_PRESCALE, {28'h0, TIC_RST_PRESCALE}, 1'b0);
    rd(TIC_OFS_BAUD, {16'h0, TIC_RST_BAUD}, 1'b0);
    rd(8'h2c, 32'h0000_0000, 1'b1);
    // Random direction to a random unaligned, hence unmapped, address
    seed = lfsr(seed);
    bus(seed[8], {seed[5:0], 2'b11}, seed);
    chk(rdat, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    // Every function, all operand pairs, chained through stage1 XOR line2
    for (int f = 0; f < 7; f++)
    begin
      bus(1'b1, TIC_OFS_CTRL, 32'(f | (4 << TIC_CTL_FUNC1) | (1 << TIC_CTL_SELB0)
        | (5 << TIC_CTL_SELA1) | (2 << TIC_CTL_SELB1) | (1 << TIC_CTL_OUT1)));
      for (int j = 0; j < 4; j++)
      begin
        seed = lfsr(seed);
        u_tic_partner.set_lines({seed[3:2], j[1:0]});
        repeat (8) @(posedge pclk);
        chk({31'h0, out_line}, {31'h0, fn(f, j[0], j[1]) ^ seed[2]});
      end
    end
    // Debounce on line0, short pulses and a bounce are suppressed
    u_tic_partner.set_lines(4'h0);
    bus(1'b1, TIC_OFS_STABLE, 32'h0000_000a);
    bus(1'b1, TIC_OFS_CTRL, 32'((4 << TIC_CTL_SELA0) | (4 << TIC_CTL_SELB0) | (1 << TIC_CTL_DBEN)));
    repeat (20) @(posedge pclk);
    u_tic_partner.set_lines(4'h1);
    repeat (7) @(posedge pclk);
    u_tic_partner.set_lines(4'h0);
    u_tic_partner.set_lines(4'h1);
    repeat (7) @(posedge pclk);
    u_tic_partner.set_lines(4'h0);
    repeat (20) @(posedge pclk);
    chk({31'h0, out_line}, 32'h0000_0000);
    u_tic_partner.set_lines(4'h1);
    repeat (8) @(posedge pclk);
    chk({31'h0, out_line}, 32'h0000_0000);
    repeat (12) @(posedge pclk);
    chk({31'h0, out_line}, 32'h0000_0001);
    // Prescaler: 2*(d+1) pulses give two triggers
    bus(1'b1, TIC_OFS_CTRL, 32'h0000_0000);
    u_tic_partner.set_lines(4'h0);
    for (int i = 0; i < 3; i++)
    begin
      n = (i == 0) ? 0 : (i == 1) ? 2 : 15;
      bus(1'b1, TIC_OFS_PRESCALE, 32'(n));
      base = trig_count;
      repeat (2 * (n + 1))
      begin
        u_tic_partner.set_lines(4'h1);
        repeat (4) @(posedge pclk);
        u_tic_partner.set_lines(4'h0);
        repeat (4) @(posedge pclk);
      end
      repeat (8) @(posedge pclk);
      chk(32'(trig_count - base), 32'h0000_0002);
    end
    // Action commands: mismatching fields refused, matching one timed
    dk = lfsr(seed);
    gk = lfsr(dk);
    bus(1'b1, TIC_OFS_DEV_KEY, dk);
    bus(1'b1, TIC_OFS_GRP_KEY, gk);
    bus(1'b1, TIC_OFS_GRP_MASK, 32'h0000_0001);
    rd(TIC_OFS_DEV_KEY, dk, 1'b0);
    for (int c = 0; c < 3; c++)
    begin
      base = trig_count;
      gm = (c == 0) ? 32'h0000_000e : (gk | 32'h0000_0001);
      u_tic_partner.send_cmd(dk ^ 32'(c == 1), gk ^ 32'(c == 2), gm);
      repeat (2600) @(posedge pclk);
      chk(32'(trig_count - base), 32'h0000_0000);
    end
    u_tic_partner.send_cmd(dk, gk, 32'h7fff_ffff);
    n = 1;
    while (cam_trigger !== 1'b1 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n * TIC_CLK_NS >= TIC_NET_MIN_NS - 2 * TIC_CLK_NS && n * TIC_CLK_NS <= TIC_NET_MAX_NS),
      32'h0000_0001);
    rd(TIC_OFS_HITS, 32'h0000_0001, 1'b0);
    // UART round trip through the echoing far end
    bus(1'b1, TIC_OFS_BAUD, BAUD);
    bus(1'b1, TIC_OFS_TXDATA, {24'h0, seed[7:0]});
    repeat (200) @(posedge pclk);
    rd(TIC_OFS_RXDATA, {23'h0, 1'b1, seed[7:0]}, 1'b0);
    // Reset in mid-run brings counters and settings back to reset values
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(TIC_OFS_HITS, 32'h0000_0000, 1'b0);
    rd(TIC_OFS_STABLE, TIC_RST_STABLE, 1'b0);
    rd(TIC_OFS_BAUD, {16'h0, TIC_RST_BAUD}, 1'b0);
    end_of_test();
  end
endmodule : tic_top_tb
